// ===== src/tfc_pkg.sv
// Package of codes, states and timing counts for the tape formatter command sequencer
package tfc_pkg;
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned READY_NS      = 2000;
    localparam int unsigned READY_CYC     = (READY_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam logic [5:0] FN_NOP         = 6'h01;
    localparam logic [5:0] FN_REW_OFF     = 6'h03;
    localparam logic [5:0] FN_REWIND      = 6'h07;
    localparam logic [5:0] FN_DCLR        = 6'h09;
    localparam logic [5:0] FN_PRESET      = 6'h11;
    localparam logic [5:0] FN_ERASE       = 6'h15;
    localparam logic [5:0] FN_WTM         = 6'h17;
    localparam logic [5:0] FN_SPC_FWD     = 6'h19;
    localparam logic [5:0] FN_SPC_REV     = 6'h1b;
    localparam logic [5:0] FN_WCHK_FWD    = 6'h29;
    localparam logic [5:0] FN_WCHK_REV    = 6'h2f;
    localparam logic [5:0] FN_WRITE       = 6'h31;
    localparam logic [5:0] FN_READ_FWD    = 6'h39;
    localparam logic [5:0] FN_READ_REV    = 6'h3f;

    // Tape control preset fields
    localparam logic [2:0] PRESET_SLAVE   = 3'h0;
    localparam logic       PRESET_ODD     = 1'b1;
    localparam logic [3:0] PRESET_FORMAT  = 4'h0;
    localparam logic [2:0] PRESET_DENSITY = 3'h3;
    localparam int unsigned TCR_SEL_LSB   = 0;
    localparam int unsigned TCR_PAR_BIT   = 3;
    localparam int unsigned TCR_FMT_LSB   = 4;
    localparam int unsigned TCR_DEN_LSB   = 8;
    localparam logic [15:0] TCR_RESET     = 16'h0000;

    // Slave motion requests
    localparam logic [2:0] MOT_NONE       = 3'h0;
    localparam logic [2:0] MOT_SPACE_F    = 3'h1;
    localparam logic [2:0] MOT_SPACE_R    = 3'h2;
    localparam logic [2:0] MOT_READ_F     = 3'h3;
    localparam logic [2:0] MOT_READ_R     = 3'h4;
    localparam logic [2:0] MOT_WRITE      = 3'h5;
    localparam logic [2:0] MOT_ERASE      = 3'h6;
    localparam logic [2:0] MOT_WTM        = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_DEFER  = 3'b001,
        ST_SETTLE = 3'b010,
        ST_REWRQ  = 3'b011,
        ST_WAIT   = 3'b100,
        ST_MOTION = 3'b101
    } tfc_state_e;
endpackage

// ===== src/tfc_timer_if.sv
// Interface between the sequencer and its delay timer
`timescale 1ns/100ps
`default_nettype none
interface tfc_timer_if;
    logic start;
    logic done;
    modport seq (output start, input done);
    modport tmr (input start, output done);
endinterface
`default_nettype wire

// ===== src/tfc_timer.sv
// Ready-delay timer: pulses done a fixed count after start
`timescale 1ns/100ps
`default_nettype none
module tfc_timer
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    tfc_timer_if.tmr  tif
);
    logic [7:0] count;
    logic       run;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count <= 8'h00;
            run   <= 1'b0;
        end
        else if (tif.start)
        begin
            count <= 8'(tfc_pkg::READY_CYC - 2);
            run   <= 1'b1;
        end
        else if (run)
        begin
            count <= count - 8'h01;
            run   <= (count != 8'h00);
        end
    end

    assign tif.done = run && (count == 8'h00);
endmodule
`default_nettype wire

// ===== src/tfc_seq.sv
// Command decoder and sequencer for the tape formatter
// Function
// [RULE1] Undefined function codes are illegal and never executed.
// [RULE2] Only drive clear runs on an off-line transport.
// [RULE3] No-op: go clear, ready; no motion, no attention.
// [RULE4] Rewind off-line: go clear, ready, status change, one attention.
// [RULE5] Rewind: ready, positioning, attention; status change at BOT.
// [RULE6] Drive clear resets formatter and selected transport only.
// [RULE7] Read-in preset loads control defaults, then rewinds slave 0.
// [RULE8] Erase gap, then clear go and set attention.
// [RULE9] Write tape mark, then clear go and set attention.
// [RULE10] Space forward by frame count; stop on mark or end.
// [RULE11] Space reverse by frame count; stop on mark or BOT.
// [RULE12] Write checks act as reads in the same direction.
// [RULE13] Write one record; clear go at end.
// [RULE14] Read one record forward or reverse; clear go at end.
// [RULE15] Rewind starts at once if settled or last motion reversed.
// [RULE16] Rewind after forward motion waits for settle to clear.
// [RULE17] Ready and attention on acceptance: 2 us, later if delayed.
// [RULE18] BOT raises status change and attention, merged if already there.
// [RULE19] Before rewind start: ready, attention, change, slave attn, positioning low.
// [RULE20] Software polls all slaves before clearing status change.
// [RULE21] Software commands a rewinding slave only while ready.
// [RULE22] Command to rewinding slave keeps go, waits for rewind end.
// [RULE23] Drive clear is accepted even with medium off-line.
`timescale 1ns/100ps
`default_nettype none
module tfc_seq
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cmd_write_i,
    input  wire logic [5:0]  func_code_i,
    input  wire logic        go_i,
    input  wire logic [2:0]  slave_sel_i,
    input  wire logic        tcr_write_i,
    input  wire logic [15:0] tcr_data_i,
    input  wire logic        ssc_clear_i,
    input  wire logic        ata_clear_i,
    input  wire logic [7:0]  medium_online_i,
    input  wire logic [7:0]  rewinding_i,
    input  wire logic [7:0]  at_bot_i,
    input  wire logic        settle_down_i,
    input  wire logic        motion_done_i,
    input  wire logic        tape_mark_i,
    input  wire logic        end_of_tape_i,
    output logic             go_o,
    output logic             drive_ready_flag_o,
    output logic             attention_active_o,
    output logic             slave_status_change_o,
    output logic             positioning_in_progress_o,
    output logic             slave_attention_o,
    output logic             tape_mark_seen_o,
    output logic             illegal_func_o,
    output logic [15:0]      tape_control_reg_o,
    output logic [2:0]       active_slave_o,
    output logic             rewind_start_o,
    output logic             rewind_offline_o,
    output logic [2:0]       motion_o,
    output logic             motion_abort_o,
    output logic             slave_clear_o
);
    tfc_pkg::tfc_state_e state;
    tfc_pkg::tfc_state_e next_state;

    tfc_timer_if tif ();
    tfc_timer u_timer
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tif   (tif)
    );

    logic [5:0] func;
    logic [2:0] sel;
    logic       last_reverse;
    logic       rew_at_bot;
    logic       merge_pending;
    logic [7:0] pip_slaves;
    logic [7:0] rew_q1;
    logic [7:0] rew_q2;
    logic [7:0] bot_q1;
    logic [7:0] bot_q2;
    logic [7:0] mol_q1;
    logic [7:0] mol_q2;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [7:0] rew_prev;

    function automatic logic is_legal(input logic [5:0] f);
        case (f)
            tfc_pkg::FN_NOP, tfc_pkg::FN_REW_OFF, tfc_pkg::FN_REWIND,
            tfc_pkg::FN_DCLR, tfc_pkg::FN_PRESET, tfc_pkg::FN_ERASE,
            tfc_pkg::FN_WTM, tfc_pkg::FN_SPC_FWD, tfc_pkg::FN_SPC_REV,
            tfc_pkg::FN_WCHK_FWD, tfc_pkg::FN_WCHK_REV, tfc_pkg::FN_WRITE,
            tfc_pkg::FN_READ_FWD, tfc_pkg::FN_READ_REV: is_legal = 1'b1;
            default: is_legal = 1'b0;
        endcase
    endfunction

    // Maps a function to the slave motion request
    function automatic logic [2:0] motion_of(input logic [5:0] f);
        case (f)
            tfc_pkg::FN_SPC_FWD:  motion_of = tfc_pkg::MOT_SPACE_F;  // see [RULE10]
            tfc_pkg::FN_SPC_REV:  motion_of = tfc_pkg::MOT_SPACE_R;  // see [RULE11]
            tfc_pkg::FN_WCHK_FWD: motion_of = tfc_pkg::MOT_READ_F;   // see [RULE12]
            tfc_pkg::FN_WCHK_REV: motion_of = tfc_pkg::MOT_READ_R;   // see [RULE12]
            tfc_pkg::FN_READ_FWD: motion_of = tfc_pkg::MOT_READ_F;   // see [RULE14]
            tfc_pkg::FN_READ_REV: motion_of = tfc_pkg::MOT_READ_R;   // see [RULE14]
            tfc_pkg::FN_WRITE:    motion_of = tfc_pkg::MOT_WRITE;    // see [RULE13]
            tfc_pkg::FN_ERASE:    motion_of = tfc_pkg::MOT_ERASE;    // see [RULE8]
            tfc_pkg::FN_WTM:      motion_of = tfc_pkg::MOT_WTM;      // see [RULE9]
            default:              motion_of = tfc_pkg::MOT_NONE;
        endcase
    endfunction

    // Slave status pins come from the transports, off this clock
    always_ff @(posedge clk_i)
    begin
        rew_q1 <= rewinding_i;
        rew_q2 <= rew_q1;
        bot_q1 <= at_bot_i;
        bot_q2 <= bot_q1;
        mol_q1 <= medium_online_i;
        mol_q2 <= mol_q1;
        sync1  <= {settle_down_i, tape_mark_i, end_of_tape_i};
        sync2  <= sync1;
    end

    wire settle   = sync2[2];
    wire tmark    = sync2[1];
    wire eot      = sync2[0];
    wire cmd_load = cmd_write_i && go_i && (state == tfc_pkg::ST_IDLE);
    wire legal    = is_legal(func_code_i);                         // see [RULE1]
    wire is_dclr  = func_code_i == tfc_pkg::FN_DCLR;
    wire is_preset = func_code_i == tfc_pkg::FN_PRESET;
    wire [2:0] load_sel = is_preset ? tfc_pkg::PRESET_SLAVE : slave_sel_i;
    wire online   = mol_q2[load_sel] || rew_q2[load_sel];
    // Drive clear bypasses the on-line check
    wire may_run  = legal && (is_dclr || online);                  // see [RULE2] [RULE23]
    wire is_rew   = (func_code_i == tfc_pkg::FN_REWIND) || is_preset
                    || (func_code_i == tfc_pkg::FN_REW_OFF);
    wire rew_now  = !settle || last_reverse;                        // see [RULE15]
    wire sel_rewinding = rew_q2[load_sel];
    wire [5:0] run_func = (state == tfc_pkg::ST_IDLE) ? func_code_i : func;
    wire mot_end  = motion_done_i
                    || (((func == tfc_pkg::FN_SPC_FWD) && (tmark || eot)))
                    || (((func == tfc_pkg::FN_SPC_REV) && (tmark || bot_q2[sel])));
    wire [7:0] bot_reached = pip_slaves & ~rew_q2 & rew_prev;
    wire busy_state = (state != tfc_pkg::ST_IDLE) && (state != tfc_pkg::ST_DEFER);

    always_comb
    begin
        next_state = state;
        case (state)
            tfc_pkg::ST_IDLE:
                if (cmd_load && may_run && !is_dclr && func_code_i != tfc_pkg::FN_NOP)
                begin
                    if (sel_rewinding)
                        next_state = tfc_pkg::ST_DEFER;            // see [RULE22]
                    else if (is_rew)
                        next_state = rew_now ? tfc_pkg::ST_REWRQ : tfc_pkg::ST_SETTLE;
                    else
                        next_state = tfc_pkg::ST_MOTION;
                end
            tfc_pkg::ST_DEFER:
                if (!rew_q2[sel])
                    next_state = (motion_of(func) == tfc_pkg::MOT_NONE)
                                 ? tfc_pkg::ST_REWRQ : tfc_pkg::ST_MOTION;
            tfc_pkg::ST_SETTLE:
                if (!settle)
                    next_state = tfc_pkg::ST_REWRQ;                // see [RULE16]
            tfc_pkg::ST_REWRQ:
                next_state = tfc_pkg::ST_WAIT;
            tfc_pkg::ST_WAIT:
                if (tif.done)
                    next_state = tfc_pkg::ST_IDLE;                 // see [RULE17]
            tfc_pkg::ST_MOTION:
                if (mot_end)
                    next_state = tfc_pkg::ST_IDLE;
            default:
                next_state = tfc_pkg::ST_IDLE;
        endcase
    end

    // Ready delay counts from the rewind request
    assign tif.start = (next_state == tfc_pkg::ST_REWRQ);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state              <= tfc_pkg::ST_IDLE;
            func               <= 6'h00;
            sel                <= 3'h0;
            go_o               <= 1'b0;
            drive_ready_flag_o <= 1'b1;
            attention_active_o <= 1'b0;
            slave_status_change_o <= 1'b0;
            slave_attention_o  <= 1'b0;
            tape_mark_seen_o   <= 1'b0;
            illegal_func_o     <= 1'b0;
            tape_control_reg_o <= tfc_pkg::TCR_RESET;
            last_reverse       <= 1'b0;
            rew_at_bot         <= 1'b0;
            merge_pending      <= 1'b0;
            pip_slaves         <= 8'h00;
            rew_prev           <= 8'h00;
            rewind_start_o     <= 1'b0;
            rewind_offline_o   <= 1'b0;
            motion_o           <= tfc_pkg::MOT_NONE;
            motion_abort_o     <= 1'b0;
            slave_clear_o      <= 1'b0;
        end
        else
        begin
            state          <= next_state;
            rew_prev       <= rew_q2;
            rewind_start_o <= 1'b0;
            slave_clear_o  <= 1'b0;
            motion_abort_o <= 1'b0;
            if (tcr_write_i && !busy_state)
                tape_control_reg_o <= tcr_data_i;
            if (cmd_load)
            begin
                func           <= func_code_i;
                sel            <= load_sel;
                illegal_func_o <= !legal;                          // see [RULE1]
                if (is_preset)                                     // see [RULE7]
                begin
                    tape_control_reg_o <= tfc_pkg::TCR_RESET
                        | (16'(tfc_pkg::PRESET_SLAVE) << tfc_pkg::TCR_SEL_LSB)
                        | (16'(tfc_pkg::PRESET_ODD) << tfc_pkg::TCR_PAR_BIT)
                        | (16'(tfc_pkg::PRESET_FORMAT) << tfc_pkg::TCR_FMT_LSB)
                        | (16'(tfc_pkg::PRESET_DENSITY) << tfc_pkg::TCR_DEN_LSB);
                end
                if (!may_run || func_code_i == tfc_pkg::FN_NOP)
                    go_o <= 1'b0;                                  // see [RULE3]
                else if (is_dclr)
                begin
                    // Selected slave only; rewinding slaves are left alone
                    go_o               <= 1'b0;                    // see [RULE6]
                    slave_clear_o      <= 1'b1;
                    slave_attention_o  <= 1'b0;
                    tape_mark_seen_o   <= 1'b0;
                    attention_active_o <= 1'b0;
                    illegal_func_o     <= 1'b0;
                    if (pip_slaves == 8'h00)
                        slave_status_change_o <= 1'b0;
                end
                else
                begin
                    go_o               <= 1'b1;
                    drive_ready_flag_o <= 1'b0;
                    if (is_rew)
                    begin
                        attention_active_o    <= 1'b0;             // see [RULE19]
                        slave_status_change_o <= 1'b0;
                        slave_attention_o     <= 1'b0;
                    end
                end
            end
            else if (ssc_clear_i)
                slave_status_change_o <= 1'b0;
            if (ata_clear_i && !cmd_load)
                attention_active_o <= 1'b0;

            if (state != tfc_pkg::ST_MOTION && next_state == tfc_pkg::ST_MOTION)
            begin
                motion_o     <= motion_of(run_func);
                last_reverse <= motion_of(run_func) inside {tfc_pkg::MOT_SPACE_R,
                    tfc_pkg::MOT_READ_R};
            end

            if (next_state == tfc_pkg::ST_REWRQ)
            begin
                rewind_start_o   <= 1'b1;
                rewind_offline_o <= (run_func == tfc_pkg::FN_REW_OFF);
                rew_at_bot       <= bot_q2[(state == tfc_pkg::ST_IDLE) ? load_sel : sel];
            end

            // Slave took the rewind; BOT merges here
            if (state == tfc_pkg::ST_WAIT && tif.done)
            begin
                go_o               <= 1'b0;
                drive_ready_flag_o <= 1'b1;                        // see [RULE17]
                attention_active_o <= 1'b1;
                last_reverse       <= 1'b1;
                if (rewind_offline_o || rew_at_bot)
                    slave_status_change_o <= 1'b1;                 // see [RULE4] [RULE18]
                else
                    pip_slaves[sel] <= 1'b1;                       // see [RULE5]
            end

            if (state == tfc_pkg::ST_MOTION && mot_end)
            begin
                go_o               <= 1'b0;                        // see [RULE13] [RULE14]
                drive_ready_flag_o <= 1'b1;
                motion_o           <= tfc_pkg::MOT_NONE;
                motion_abort_o     <= !motion_done_i;              // see [RULE10] [RULE11]
                if (tmark)
                    tape_mark_seen_o <= 1'b1;
                // Erase, mark and spaces always attend; others only if their slave reached BOT while deferred
                if (func == tfc_pkg::FN_ERASE || func == tfc_pkg::FN_WTM
                    || func == tfc_pkg::FN_SPC_FWD || func == tfc_pkg::FN_SPC_REV
                    || merge_pending)
                    attention_active_o <= 1'b1;                    // see [RULE8] [RULE9]
                merge_pending <= 1'b0;
            end

            // End of a rewind; set beats any software clear in the same cycle
            if (bot_reached != 8'h00)
            begin
                pip_slaves            <= pip_slaves & ~bot_reached;
                slave_status_change_o <= 1'b1;                     // see [RULE5] [RULE18]
                attention_active_o    <= 1'b1;
                if (state == tfc_pkg::ST_DEFER && bot_reached[sel])
                    merge_pending <= 1'b1;                         // see [RULE22]
            end
        end
    end

    assign positioning_in_progress_o = pip_slaves[sel] && (state != tfc_pkg::ST_REWRQ)
                                       && (state != tfc_pkg::ST_WAIT);  // see [RULE19]
    assign active_slave_o = sel;
endmodule
`default_nettype wire

// ===== sim/tfc_properties.sv
// Port checker for the tape formatter sequencer
`timescale 1ns/100ps
`default_nettype none
module tfc_properties
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cmd_write_i,
    input wire logic [5:0]  func_code_i,
    input wire logic        go_i,
    input wire logic [2:0]  slave_sel_i,
    input wire logic [7:0]  medium_online_i,
    input wire logic [7:0]  rewinding_i,
    input wire logic        settle_down_i,
    input wire logic        motion_done_i,
    input wire logic        go_o,
    input wire logic        drive_ready_flag_o,
    input wire logic        attention_active_o,
    input wire logic        slave_status_change_o,
    input wire logic        positioning_in_progress_o,
    input wire logic        slave_attention_o,
    input wire logic        illegal_func_o,
    input wire logic [15:0] tape_control_reg_o,
    input wire logic [2:0]  motion_o,
    input wire logic        slave_clear_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire take = cmd_write_i && go_i && drive_ready_flag_o && !go_o;
    wire onl  = medium_online_i[slave_sel_i];
    wire rwg  = rewinding_i[slave_sel_i];
    wire legal = func_code_i inside {6'h01, 6'h03, 6'h07, 6'h09, 6'h11, 6'h15, 6'h17,
        6'h19, 6'h1b, 6'h29, 6'h2f, 6'h31, 6'h39, 6'h3f};
    wire rew  = func_code_i == tfc_pkg::FN_REWIND || func_code_i == tfc_pkg::FN_REW_OFF;
    // Motions that must end with attention
    wire endm = motion_o inside {3'h1, 3'h2, 3'h6, 3'h7};
    sequence s_rew_load;
        take && !rwg && rew && onl && !settle_down_i;
    endsequence
    sequence s_quiet;
        !drive_ready_flag_o && !attention_active_o && !slave_status_change_o
            && !slave_attention_o && !positioning_in_progress_o;
    endsequence
    a_rew_quiet: assert property (s_rew_load |=> s_quiet [*8])
        else $error("status flags high before rewind start");
    a_rew_ready: assert property (
        s_rew_load |-> ##20 drive_ready_flag_o && attention_active_o)
        else $error("ready or attention late after rewind");
    a_nop_done: assert property (
        take && !rwg && func_code_i == tfc_pkg::FN_NOP |=> !go_o && drive_ready_flag_o)
        else $error("no-op did not finish at once");
    a_illegal_func: assert property (take && !legal |=> illegal_func_o && !go_o)
        else $error("illegal code not flagged");
    a_offline_refused: assert property (
        take && !onl && !rwg && func_code_i != tfc_pkg::FN_DCLR |=> (!go_o && motion_o == 3'h0) [*4])
        else $error("command ran on off-line slave");
    a_clear_pulse: assert property (
        take && func_code_i == tfc_pkg::FN_DCLR |-> ##[1:2] slave_clear_o)
        else $error("drive clear gave no slave clear");
    a_preset_tcr: assert property (
        take && !rwg && onl && func_code_i == tfc_pkg::FN_PRESET
        |-> ##[1:3] tape_control_reg_o == 16'h0308)
        else $error("preset value wrong");
    a_motion_go: assert property ($rose(motion_o != 3'h0) |-> go_o)
        else $error("motion without go");
    a_motion_end: assert property (
        motion_done_i && motion_o != 3'h0 |=> !go_o && (attention_active_o || !$past(endm)))
        else $error("motion end not reported");
endmodule
`default_nettype wire

// ===== sim/tfc_slave_model.sv
// Behavioural tape transports facing the sequencer
`timescale 1ns/100ps
`default_nettype none
module tfc_slave_model
(
    input  wire logic       clk_i,
    input  wire logic       slow_i,
    input  wire logic       mark_i,
    input  wire logic [2:0] motion_i,
    input  wire logic       rewind_start_i,
    input  wire logic       rewind_offline_i,
    input  wire logic [2:0] slave_i,
    output logic            done_o = 1'h0,
    output logic            mark_o = 1'h0,
    output logic [7:0]      online_o = 8'hdf,
    output logic [7:0]      rewinding_o = 8'h00,
    output logic [7:0]      bot_o = 8'h01
);
    int         mcnt = 0;
    int         rcnt = 0;
    logic [2:0] rsl = 3'h0;
    // One rewind at a time
    always @(posedge clk_i)
    begin
        done_o <= 1'h0;
        mark_o <= 1'h0;
        mcnt <= (motion_i == 3'h0 || done_o || mark_o) ? 0 : mcnt + 1;
        if (mcnt == (slow_i ? 60 : 8))
        begin
            if (mark_i && motion_i inside {tfc_pkg::MOT_SPACE_F, tfc_pkg::MOT_SPACE_R})
                mark_o <= 1'h1;
            else
                done_o <= 1'h1;
        end
        if (motion_i != 3'h0)
            bot_o[slave_i] <= 1'h0;
        if (rcnt > 0)
            rcnt <= rcnt - 1;
        if (rcnt == 1)
        begin
            rewinding_o[rsl] <= 1'h0;
            bot_o[rsl] <= 1'h1;
        end
        if (rewind_start_i)
        begin
            rsl <= slave_i;
            rewinding_o[slave_i] <= 1'h1;
            bot_o[slave_i] <= 1'h0;
            rcnt <= 300;
            if (rewind_offline_i)
                online_o[slave_i] <= 1'h0;
        end
    end
endmodule
`default_nettype wire

// ===== sim/test_tfc_seq.sv
// Self-checking bench of the sequencer
`timescale 1ns/100ps
`default_nettype none
module test_tfc_seq;
    logic        clk_i = 1'h0, rst_i = 1'h1, cmd_write_i = 1'h0, go_i = 1'h0;
    logic        tcr_write_i = 1'h0, ssc_clear_i = 1'h0, ata_clear_i = 1'h0;
    logic        settle_down_i = 1'h0, end_of_tape_i = 1'h0, slow = 1'h0, mark = 1'h0;
    logic [5:0]  func_code_i = 6'h00;
    logic [2:0]  slave_sel_i = 3'h0, active_slave_o, motion_o;
    logic [15:0] tcr_data_i = 16'h0000, tape_control_reg_o;
    logic [7:0]  medium_online_i, rewinding_i, at_bot_i;
    logic        motion_done_i, tape_mark_i, go_o, drive_ready_flag_o, attention_active_o;
    logic        slave_status_change_o, positioning_in_progress_o, slave_attention_o;
    logic        tape_mark_seen_o, illegal_func_o, rewind_start_o, rewind_offline_o;
    logic        motion_abort_o, slave_clear_o;
    logic [31:0] rs = 32'h1a2c;
    int          mismatches = 0, n_checks = 0, cyc = 0;
    logic [5:0]  pick [10] = '{6'h01, 6'h15, 6'h17, 6'h19, 6'h1b, 6'h29, 6'h2f, 6'h31,
        6'h39, 6'h3f};
    tfc_seq DUT (.*);
    tfc_slave_model u_slaves (.clk_i(clk_i), .slow_i(slow), .mark_i(mark), .motion_i(motion_o),
        .rewind_start_i(rewind_start_o), .rewind_offline_i(rewind_offline_o),
        .slave_i(active_slave_o), .done_o(motion_done_i), .mark_o(tape_mark_i),
        .online_o(medium_online_i), .rewinding_o(rewinding_i), .bot_o(at_bot_i));
    always #50 clk_i = ~clk_i;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    function automatic logic [2:0] emot(input logic [5:0] f);
        case (f)
            6'h19: return tfc_pkg::MOT_SPACE_F;
            6'h1b: return tfc_pkg::MOT_SPACE_R;
            6'h29, 6'h39: return tfc_pkg::MOT_READ_F;
            6'h2f, 6'h3f: return tfc_pkg::MOT_READ_R;
            6'h31: return tfc_pkg::MOT_WRITE;
            6'h15: return tfc_pkg::MOT_ERASE;
            6'h17: return tfc_pkg::MOT_WTM;
            default: return tfc_pkg::MOT_NONE;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic cmd(input logic [5:0] f, input logic [2:0] s);
        tick(1);
        {cmd_write_i, go_i, func_code_i, slave_sel_i} = {2'h3, f, s};
        tick(1);
        {cmd_write_i, go_i} = 2'h0;
    endtask
    task automatic idle(input int lim);
        int n = 0;
        tick(1);
        while ((go_o !== 1'h0 || drive_ready_flag_o !== 1'h1) && n < lim)
        begin
            tick(1);
            n++;
        end
        chk("idle", n < lim, 1'h1);
    endtask
    task automatic clr();
        tick(1);
        {ata_clear_i, ssc_clear_i} = 2'h3;
        tick(1);
        {ata_clear_i, ssc_clear_i} = 2'h0;
    endtask
    always @(posedge clk_i)
    begin
        cyc++;
        // Whole run needs about 3000 cycles
        if (cyc == 30000)
        begin
            mismatches++;
            summarize();
        end
    end
    initial
    begin
        logic [5:0] f;
        logic [2:0] s;
        int n;
        tick(16);
        rst_i = 1'h0;
        tick(1);
        chk("reset", {go_o, drive_ready_flag_o, tape_control_reg_o[13:0]}, 16'h4000);
        repeat (40)
        begin
            rs = xs(rs);
            f = rs[6] ? pick[rs[11:8] % 10] : rs[5:0];
            if (f inside {6'h03, 6'h07, 6'h11})
                f = 6'h09;
            s = rs[14:12];
            {slow, mark} = rs[17:16];
            cmd(f, s);
            for (n = 0; n < 4 && motion_o === 3'h0; n++)
                tick(1);
            if (medium_online_i[s])
                chk("motion", motion_o, emot(f));
            idle(300);
            if (emot(f) == 3'h0 && !(f inside {6'h01, 6'h09}))
                chk("illegal", illegal_func_o, 1'h1);
            else if (medium_online_i[s] && f inside {6'h15, 6'h17, 6'h19, 6'h1b})
                chk("attn", attention_active_o, 1'h1);
            else if (medium_online_i[s] && f == 6'h01)
                chk("nop", attention_active_o, 1'h0);
            clr();
        end
        cmd(6'h09, 3'h5);
        chk("dclr", slave_clear_o, 1'h1);
        idle(40);
        cmd(6'h11, 3'h4);
        idle(40);
        chk("preset", tape_control_reg_o, 16'h0308);
        tick(320);
        cmd(6'h07, 3'h1);
        idle(40);
        chk("pip", positioning_in_progress_o, 1'h1);
        tick(320);
        chk("bot", {slave_status_change_o, positioning_in_progress_o}, 2'h2);
        cmd(6'h07, 3'h2);
        idle(40);
        clr();
        cmd(6'h17, 3'h2);
        tick(10);
        chk("defer", go_o, 1'h1);
        idle(600);
        chk("defer_end", {slave_status_change_o, attention_active_o}, 2'h3);
        cmd(6'h19, 3'h4);
        idle(300);
        settle_down_i = 1'h1;
        tick(3);
        cmd(6'h07, 3'h4);
        tick(60);
        chk("held", drive_ready_flag_o, 1'h0);
        settle_down_i = 1'h0;
        idle(100);
        tick(320);
        clr();
        cmd(6'h03, 3'h3);
        idle(40);
        chk("rew_off", {slave_status_change_o, attention_active_o}, 2'h3);
        tick(320);
        cmd(6'h01, 3'h3);
        idle(40);
        summarize();
    end
endmodule
bind tfc_seq tfc_properties u_props (.*);
`default_nettype wire
